// File: solenoid_pickup_hold_driver.sv
// Pull-in then hold drive for fourteen on/off outputs, AHB-Lite programmed
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module solenoid_pickup_hold_driver #(
  parameter int unsigned TICK_CYCLES = solenoid_drive_pkg::PULLIN_STEP_CYCLES,
  parameter int unsigned SLOT_CYCLES = solenoid_drive_pkg::PWM_SLOT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Activation commands and outputs
  input wire logic [solenoid_drive_pkg::CHANNELS-1:0] cmd_on_in,
  output logic [solenoid_drive_pkg::CHANNELS-1:0] drive_out
);
  import solenoid_drive_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);

  logic accept;
  logic wr_pend_q;
  logic rd_wait_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_d;
  logic [PULL_W-1:0] pull_q [CHANNELS];
  logic [DUTY_W-1:0] duty_q [CHANNELS];
  logic [CHANNELS-1:0] active_q;
  logic [CHANNELS-1:0] pulling_q;
  logic [CHANNELS-1:0] drive_q;
  logic [SLOT_W-1:0] slot_cnt_q;
  logic [3:0] slot_q;

  // ===========================================================
  // Bus slave: writes zero-wait, reads one wait state
  assign accept = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = !rd_wait_q;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= accept && hwrite_in && (hsize_in == SIZE_WORD);
      rd_wait_q <= accept && !hwrite_in;
      if (accept) begin
        addr_q <= haddr_in[7:0];
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (addr_q[7:6] == PULL_OFS[7:6] && 32'(addr_q[5:2]) < CHANNELS) begin
      rd_d[PULL_W-1:0] = pull_q[addr_q[5:2]];
    end else if (addr_q[7:6] == DUTY_OFS[7:6] && 32'(addr_q[5:2]) < CHANNELS) begin
      rd_d[DUTY_W-1:0] = duty_q[addr_q[5:2]];
    end else if (addr_q == STATUS_OFS) begin
      rd_d = {2'b00, pulling_q, 2'b00, drive_q};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      hrdata_q <= rd_d;
    end
  end

  // ===========================================================
  // Shared hold waveform: ten slots per period
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      slot_cnt_q <= '0;
      slot_q <= 4'h0;
    end else if (slot_cnt_q == SLOT_W'(SLOT_CYCLES - 1)) begin
      slot_cnt_q <= '0;
      slot_q <= (slot_q == 4'(PWM_SLOTS - 1)) ? 4'h0 : slot_q + 4'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + SLOT_W'(1);
    end
  end

  assign drive_out = drive_q;

  // ===========================================================
  // Per-channel settings and pull-in/hold engine
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    localparam logic [7:0] PULL_ADDR = 8'(PULL_OFS + 4 * i);
    localparam logic [7:0] DUTY_ADDR = 8'(DUTY_OFS + 4 * i);
    logic start;
    logic [PRE_W-1:0] pre_q;
    logic [PULL_W-1:0] left_q;

    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        pull_q[i] <= PULL_RST[i];
      end else if (wr_pend_q && addr_q == PULL_ADDR) begin
        pull_q[i] <= (hwdata_in[PULL_W-1:0] == '0) ? PULL_MIN : hwdata_in[PULL_W-1:0];
      end
    end

    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        duty_q[i] <= DUTY_RST[i];
      end else if (wr_pend_q && addr_q == DUTY_ADDR) begin
        duty_q[i] <= (hwdata_in > 32'(DUTY_MAX)) ? DUTY_MAX : hwdata_in[DUTY_W-1:0];
      end
    end

    assign start = cmd_on_in[i] && !active_q[i];

    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        active_q[i] <= 1'b0;
        pulling_q[i] <= 1'b0;
        pre_q <= '0;
        left_q <= '0;
      end else if (!cmd_on_in[i]) begin
        active_q[i] <= 1'b0;
        pulling_q[i] <= 1'b0;
      end else if (start) begin
        active_q[i] <= 1'b1;
        pulling_q[i] <= 1'b1;
        pre_q <= PRE_W'(TICK_CYCLES - 1);
        left_q <= pull_q[i];
      end else if (pulling_q[i]) begin
        if (pre_q == '0) begin
          pre_q <= PRE_W'(TICK_CYCLES - 1);
          left_q <= left_q - PULL_W'(1);
          if (left_q == PULL_MIN) begin
            pulling_q[i] <= 1'b0;
          end
        end else begin
          pre_q <= pre_q - PRE_W'(1);
        end
      end
    end

    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        drive_q[i] <= 1'b0;
      end else begin
        drive_q[i] <= cmd_on_in[i] && (start || pulling_q[i] ||
          (slot_q < duty_q[i]));
      end
    end

    // Assertions
    sequence start_seq;
      cmd_on_in[i] && !active_q[i];
    endsequence

    sequence pull_seq;
      drive_out[i] && pulling_q[i];
    endsequence

    pull_start_a: assert property (@(posedge clk_in) disable iff (srst_in)
      start_seq |=> pull_seq)
      else $error("pull-in did not start on activation");

    pull_full_a: assert property (@(posedge clk_in) disable iff (srst_in)
      pulling_q[i] && cmd_on_in[i] |=> drive_out[i])
      else $error("output not full on during pull-in");

    pull_len_a: assert property (@(posedge clk_in) disable iff (srst_in)
      pulling_q[i] && cmd_on_in[i] && !start && pre_q == '0 && left_q == PULL_MIN
      |=> !pulling_q[i])
      else $error("pull-in did not end after programmed ticks");

    pull_code_a: assert property (@(posedge clk_in) disable iff (srst_in)
      pull_q[i] != '0)
      else $error("pull-in setting below one step");

    rst_pull_a: assert property (@(posedge clk_in) disable iff (srst_in)
      $past(srst_in) |-> pull_q[i] == PULL_RST[i])
      else $error("pull-in reset value wrong");

    rst_duty_a: assert property (@(posedge clk_in) disable iff (srst_in)
      $past(srst_in) |-> duty_q[i] == DUTY_RST[i])
      else $error("duty reset value wrong");

    hold_duty_a: assert property (@(posedge clk_in) disable iff (srst_in)
      active_q[i] && !pulling_q[i] && cmd_on_in[i]
      |=> drive_out[i] == ($past(slot_q) < $past(duty_q[i])))
      else $error("hold output does not follow duty");

    duty_range_a: assert property (@(posedge clk_in) disable iff (srst_in)
      duty_q[i] <= DUTY_MAX)
      else $error("duty above full scale");

    zero_duty_a: assert property (@(posedge clk_in) disable iff (srst_in)
      active_q[i] && !pulling_q[i] && cmd_on_in[i] && duty_q[i] == '0 |=> !drive_out[i])
      else $error("zero duty left output on");

    off_now_a: assert property (@(posedge clk_in) disable iff (srst_in)
      !cmd_on_in[i] |=> !drive_out[i] && !active_q[i] && !pulling_q[i])
      else $error("output stayed on after command off");

    pull_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_pend_q && addr_q == PULL_ADDR && hwdata_in[PULL_W-1:0] != '0
      |=> pull_q[i] == PULL_W'($past(hwdata_in)))
      else $error("pull-in write did not land");

    duty_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_pend_q && addr_q == DUTY_ADDR && hwdata_in <= 32'(DUTY_MAX)
      |=> duty_q[i] == DUTY_W'($past(hwdata_in)))
      else $error("duty write did not land");

    duty_clamp_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_pend_q && addr_q == DUTY_ADDR && hwdata_in > 32'(DUTY_MAX)
      |=> duty_q[i] == DUTY_MAX)
      else $error("duty above full scale not clamped");

    pull_active_a: assert property (@(posedge clk_in) disable iff (srst_in)
      pulling_q[i] |-> active_q[i])
      else $error("pull-in phase without activation");

    pull_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
      start |=> left_q == $past(pull_q[i]) && pre_q == PRE_W'(TICK_CYCLES - 1))
      else $error("pull-in count not loaded from setting");

    hold_full_a: assert property (@(posedge clk_in) disable iff (srst_in)
      active_q[i] && !pulling_q[i] && cmd_on_in[i] && duty_q[i] == DUTY_MAX
      |=> drive_out[i])
      else $error("full-scale duty not continuously on");
  end

  // ===========================================================
  // Channel-specific reset checks, hold slot checks and bus checks
  bt_pull_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> pull_q[CH_BT] == PULL_BT)
    else $error("reverse pull-in not 1020 ms after reset");

  pf_pull_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> pull_q[CH_PF] == PULL_PF)
    else $error("presser pull-in not 200 ms after reset");

  bt_duty_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> duty_q[CH_BT] == DUTY_HALF)
    else $error("reverse duty not 50 percent after reset");

  pf_duty_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> duty_q[CH_PF] == DUTY_PF)
    else $error("presser duty not 20 percent after reset");

  twin_duty_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> duty_q[CH_LEFT] == DUTY_HALF && duty_q[CH_RIGHT] == DUTY_HALF)
    else $error("twin needle duty not 50 percent after reset");

  slot_wrap_a: assert property (@(posedge clk_in) disable iff (srst_in)
    slot_cnt_q == SLOT_W'(SLOT_CYCLES - 1) && slot_q == 4'(PWM_SLOTS - 1)
    |=> slot_q == 4'h0 && slot_cnt_q == '0)
    else $error("hold period did not wrap after ten slots");

  read_wait_a: assert property (@(posedge clk_in) disable iff (srst_in)
    accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read answer not after one wait state");

  write_ready_a: assert property (@(posedge clk_in) disable iff (srst_in)
    accept && hwrite_in |=> hreadyout_out)
    else $error("write data phase was stretched");

  resp_okay_a: assert property (@(posedge clk_in) disable iff (srst_in)
    hresp_out == 1'b0)
    else $error("error response on the bus");

  rdata_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !rd_wait_q |=> $stable(hrdata_out))
    else $error("read data changed outside a read");

  slot_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    slot_cnt_q != SLOT_W'(SLOT_CYCLES - 1) |=> $stable(slot_q))
    else $error("hold slot advanced early");

  slot_range_a: assert property (@(posedge clk_in) disable iff (srst_in)
    slot_q < 4'(PWM_SLOTS))
    else $error("hold slot out of range");

endmodule // solenoid_pickup_hold_driver

// File: solenoid_drive_pkg.sv
// Constants shared by the solenoid pull-in and hold driver
package solenoid_drive_pkg;
  // ===========================================================
  // Channels and clock
  localparam int CHANNELS = 14;
  localparam int CLK_HZ = 250_000_000;
  localparam int CH_BT = 0;
  localparam int CH_PF = 1;
  localparam int CH_LEFT = 5;
  localparam int CH_RIGHT = 6;
  // ===========================================================
  // Timing
  localparam int PULLIN_STEP_MS = 4;
  localparam int PULLIN_STEP_CYCLES = CLK_HZ / 1000 * PULLIN_STEP_MS;
  localparam int PWM_PERIOD_US = 1000;
  localparam int PWM_SLOTS = 10;
  localparam int PWM_SLOT_CYCLES = CLK_HZ / 1_000_000 * PWM_PERIOD_US / PWM_SLOTS;
  // ===========================================================
  // Field widths and limits
  localparam int PULL_W = 8;
  localparam int DUTY_W = 4;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 4'hA;
  localparam logic [PULL_W-1:0] PULL_MIN = 8'h01;
  // ===========================================================
  // Reset values
  localparam int PULL_BT_MS = 1020;
  localparam int PULL_PF_MS = 200;
  localparam int PULL_STD_MS = 100;
  localparam logic [PULL_W-1:0] PULL_BT = PULL_W'(PULL_BT_MS / PULLIN_STEP_MS);
  localparam logic [PULL_W-1:0] PULL_PF = PULL_W'(PULL_PF_MS / PULLIN_STEP_MS);
  localparam logic [PULL_W-1:0] PULL_STD = PULL_W'(PULL_STD_MS / PULLIN_STEP_MS);
  localparam logic [PULL_W-1:0] PULL_RST [CHANNELS] = '{PULL_BT, PULL_PF, PULL_STD,
    PULL_STD, PULL_STD, PULL_STD, PULL_STD, PULL_STD, PULL_STD, PULL_STD, PULL_STD,
    PULL_STD, PULL_STD, PULL_STD};
  localparam logic [DUTY_W-1:0] DUTY_HALF = 4'h5;
  localparam logic [DUTY_W-1:0] DUTY_PF = 4'h2;
  localparam logic [DUTY_W-1:0] DUTY_RST [CHANNELS] = '{DUTY_HALF, DUTY_PF, DUTY_MAX,
    DUTY_MAX, DUTY_MAX, DUTY_HALF, DUTY_HALF, DUTY_MAX, DUTY_MAX, DUTY_MAX, DUTY_MAX,
    DUTY_MAX, DUTY_MAX, DUTY_MAX};
  // ===========================================================
  // Register map (byte offsets)
  localparam logic [7:0] PULL_OFS = 8'h00;
  localparam logic [7:0] DUTY_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h80;
  localparam logic [2:0] SIZE_WORD = 3'h2;
endpackage

// File: solenoid_load_model.sv
// Behavioural load that counts the energised cycles of one selected output
`timescale 1ns/1ps
module solenoid_load_model (
  // Clock and measurement control
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic [3:0] sel_in,
  // Outputs of the driver
  input wire logic [solenoid_drive_pkg::CHANNELS-1:0] drive_in,
  // Energised cycles since the last clear
  output logic [15:0] on_cnt_out
);
  import solenoid_drive_pkg::*;
  // ===========================================================
  // Energised cycle counter
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      on_cnt_out <= 16'h0000;
    end else if (drive_in[sel_in]) begin
      on_cnt_out <= on_cnt_out + 16'h0001;
    end
  end
endmodule // solenoid_load_model

// File: solenoid_pickup_hold_driver_tb_top.sv
// Self-checking testbench of the solenoid pull-in and hold driver
`timescale 1ns/1ps
module solenoid_pickup_hold_driver_tb_top;
  import solenoid_drive_pkg::*;
  localparam int TICK = 8;
  localparam int SLOT = 3;
  logic clk_in, srst_in, hsel, hwrite, hready, hresp, clr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] sel;
  logic [2:0] size_sel = SIZE_WORD;
  logic [15:0] on_cnt;
  logic [CHANNELS-1:0] cmd, drive;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ===========================================================
  // Design and load
  solenoid_pickup_hold_driver #(.TICK_CYCLES(TICK), .SLOT_CYCLES(SLOT))
    solenoid_pickup_hold_driver_i (.clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .cmd_on_in(cmd), .drive_out(drive));
  solenoid_load_model solenoid_load_model_i (.clk_in(clk_in), .clr_in(clr), .sel_in(sel),
    .drive_in(drive), .on_cnt_out(on_cnt));
  // ===========================================================
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
  // ===========================================================
  // Tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One AHB-Lite single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= size_sel;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  // Set one command, clear the load count, then count span samples
  task automatic run(input int ch, input logic on, input int span);
    cmd[ch] <= on;
    clr <= 1'b1;
    sel <= 4'(ch);
    @(posedge clk_in) clr <= 1'b0;
    repeat (span + 1) @(posedge clk_in);
  endtask
  // ===========================================================
  // Tests
  initial begin
    srst_in = 1'b1;
    {hsel, hwrite, clr, htrans, hsize, sel, haddr, hwdata, cmd} = '0;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    for (int ch = 0; ch < CHANNELS; ch++) begin
      bus(1'b0, PULL_OFS + 8'(4 * ch), 32'h0, rd);
      chk("pull reset", rd, (ch == 0) ? 32'hFF : (ch == 1) ? 32'h32 : 32'h19);
      bus(1'b0, DUTY_OFS + 8'(4 * ch), 32'h0, rd);
      chk("duty reset", rd, (ch == 0 || ch == 5 || ch == 6) ? 32'h5 :
        (ch == 1) ? 32'h2 : 32'hA);
    end
    bus(1'b0, 8'hFC, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("okay resp", 32'(hresp), 32'h0);
    wr(PULL_OFS + 8'h08, 32'h0);
    bus(1'b0, PULL_OFS + 8'h08, 32'h0, rd);
    chk("pull min", rd, 32'h1);
    wr(PULL_OFS + 8'h08, 32'hFF);
    bus(1'b0, PULL_OFS + 8'h08, 32'h0, rd);
    chk("pull max", rd, 32'hFF);
    size_sel = 3'h0;
    wr(PULL_OFS + 8'h08, 32'h7);
    size_sel = SIZE_WORD;
    bus(1'b0, PULL_OFS + 8'h08, 32'h0, rd);
    chk("narrow write", rd, 32'hFF);
    wr(DUTY_OFS + 8'h08, 32'hB);
    bus(1'b0, DUTY_OFS + 8'h08, 32'h0, rd);
    chk("duty clamp", rd, 32'hA);
    for (int d = 0; d <= 10; d++) begin
      wr(DUTY_OFS + 8'h08, 32'(d));
      bus(1'b0, DUTY_OFS + 8'h08, 32'h0, rd);
      chk("duty step", rd, 32'(d));
    end
    wr(PULL_OFS + 8'h08, 32'h2);
    wr(DUTY_OFS + 8'h08, 32'h0);
    run(2, 1'b1, 60);
    chk("pull length", 32'(on_cnt), 32'(2 * TICK + 1));
    for (int d = 1; d <= 10; d += 3) begin
      wr(DUTY_OFS + 8'h08, 32'(d));
      run(2, 1'b1, 30);
      run(2, 1'b1, 10 * SLOT);
      chk("hold period", 32'(on_cnt), 32'(d * SLOT));
    end
    cmd[3] <= 1'b1;
    bus(1'b0, STATUS_OFS, 32'h0, rd);
    chk("status", rd, 32'h0008_000C);
    cmd[3] <= 1'b0;
    @(posedge clk_in);
    run(2, 1'b0, 1);
    chk("off at once", 32'(drive[2]), 32'h0);
    chk("off count", 32'(on_cnt), 32'h0);
    wr(DUTY_OFS + 8'h08, 32'h0);
    run(2, 1'b1, 60);
    chk("restart pull", 32'(on_cnt), 32'(2 * TICK + 1));
    close_out();
  end
endmodule // solenoid_pickup_hold_driver_tb_top
